// [rtl/upcctl_map.svh]
// Register map, field positions, reset values and counts of the upconverter chip control.
// Assumes an APB master with 32-bit data and word-aligned byte addresses.
`ifndef UPCCTL_MAP_SVH
`define UPCCTL_MAP_SVH
`define UPCCTL_ADDR_CFR1 12'h000
`define UPCCTL_ADDR_CFR2 12'h004
`define UPCCTL_ADDR_CLOCK 12'h008
`define UPCCTL_ADDR_RATE 12'h00C
`define UPCCTL_ADDR_TUNE_FREQ 12'h010
`define UPCCTL_ADDR_TUNE_PHASE 12'h014
`define UPCCTL_ADDR_TUNE_AMP 12'h018
`define UPCCTL_ADDR_UPDATE 12'h01C
`define UPCCTL_ADDR_STATUS 12'h020
`define UPCCTL_ADDR_ACTIVE1 12'h024
`define UPCCTL_ADDR_ACTIVE2 12'h028
`define UPCCTL_ADDR_ACTIVE3 12'h02C
// Config 1 fields
`define UPCCTL_F_MODE_LO 0
`define UPCCTL_F_FMT 2
`define UPCCTL_F_GATE_INV 3
`define UPCCTL_F_PARALLEL_DATA_CLOCK_EN 4
`define UPCCTL_F_PARALLEL_DATA_CLOCK_INV 5
`define UPCCTL_F_PARALLEL_DATA_CLOCK_HALF 6
`define UPCCTL_F_HOLD_LAST 7
`define UPCCTL_F_DSP_EN 8
`define UPCCTL_F_DSP_LSB 9
`define UPCCTL_F_DSP_EARLY 10
`define UPCCTL_F_PD_DIG 11
`define UPCCTL_F_PD_DAC 12
`define UPCCTL_F_PD_CLK 13
`define UPCCTL_F_PD_AUX 14
`define UPCCTL_F_AUTO_SLEEP 15
`define UPCCTL_F_EXT_PD_FULL 16
`define UPCCTL_F_SYNC_ERR_EN 17
`define UPCCTL_F_SYNC_CLK_EN 18
`define UPCCTL_F_MATCHED 19
`define UPCCTL_F_INT_UPD 20
// Clock register fields
`define UPCCTL_F_DIV_OFF 0
`define UPCCTL_F_MULT_EN 1
`define UPCCTL_F_MULT_LO 2
`define UPCCTL_F_XTAL_LO 9
// Update register and status fields
`define UPCCTL_F_UPD_GO 0
`define UPCCTL_F_SYNC_ERR 0
`define UPCCTL_F_LOCK 1
`define UPCCTL_F_ASLEEP 2
`define UPCCTL_F_CLK_RUN 3
// Limits and reset values
`define UPCCTL_MULT_MIN 7'd12
`define UPCCTL_MULT_MAX 7'd127
`define UPCCTL_RST_CFR1 32'h0000_0000
`define UPCCTL_RST_CLOCK 32'h0000_0000
`define UPCCTL_RST_RATE 32'h0000_00FF
`define UPCCTL_FLUSH_CYCLES 8'd16
`define UPCCTL_MISMATCH_DELAY 2'd2
`endif

// [rtl/upcctl_pkg.sv]
// Types of the upconverter chip control.
// Assumes upcctl_map.svh supplies the numeric constants.
package upcctl_pkg;
    typedef enum logic [1:0] {
        MODE_QUADRATURE_UPCONVERT,
        MODE_SINGLE_TONE,
        MODE_INTERP_DAC,
        MODE_SPARE
    } upcctl_mode_e;
    typedef enum logic [1:0] {
        DRIVE_LOW,
        DRIVE_MIDDLE,
        DRIVE_HIGH,
        DRIVE_SPARE
    } upcctl_drive_e;
    typedef enum {
        PWR_RUN,
        PWR_FLUSH,
        PWR_SLEEP
    } upcctl_pwr_e;
endpackage : upcctl_pkg

// [rtl/upcctl_top.sv]
// Chip-level control of a quadrature upconverter: APB registers, update transfer,
// clock path, gating, power-down and sample formatting.
// Assumes an APB master on CLOCK and asynchronous pins synchronised here.
`include "upcctl_map.svh"
`timescale 1ns/1ns
`default_nettype none
module upcctl_top #(
    parameter int SAMPLE_W = 16,
    parameter int RATE_W = 16
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RESET,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Device pins
    input wire logic UPDATE_IN,
    output logic UPDATE_OUT,
    output logic UPDATE_OE,
    input wire logic TRANSMIT_GATE,
    input wire logic POWER_DOWN_PIN,
    input wire logic PLL_LOCK_RAW,
    input wire logic SYNC_ERR_RAW,
    // Sample path
    input wire logic [SAMPLE_W-1:0] SAMPLE_IN,
    input wire logic SAMPLE_VALID,
    output logic [SAMPLE_W-1:0] SAMPLE_OUT,
    output logic [SAMPLE_W-1:0] SERIAL_WORD,
    output logic [31:0] TUNE_FREQ,
    output logic [31:0] TUNE_PHASE,
    output logic [31:0] TUNE_AMP,
    // Clock and power controls
    output logic PARALLEL_DATA_CLOCK,
    output logic SYNC_CLK_OE,
    output logic REF_DIV_BYPASS,
    output logic MULT_ENABLE,
    output logic [6:0] MULT_FACTOR,
    output logic [1:0] CRYSTAL_REFERENCE_OUTPUT,
    output logic [1:0] MODE,
    output logic CORE_CLK_RUN,
    output logic BIAS_ON,
    output logic [3:0] BLOCK_PD,
    output logic SYNC_ERR_FLAG
);
    logic [31:0] hold_cfr1, hold_clock, hold_rate, hold_freq, hold_phase, hold_amp;
    logic [31:0] cfr1, clock_cfg, rate, act_freq, act_phase, act_amp;
    logic [31:0] freq_d1, freq_d2, amp_d1;
    logic [RATE_W-1:0] rate_cnt;
    logic upd_s1, upd_s2, upd_s3, gate_s1, gate_s2, pd_s1, pd_s2;
    logic lock_s1, lock_s2, serr_s1, serr_s2;
    logic sw_update, int_tick, transfer, gate_on, ser_phase;
    logic [7:0] flush_cnt;
    logic [SAMPLE_W-1:0] last_sample, shift_word;
    logic [4:0] bit_cnt;
    logic sync_armed;
    upcctl_pkg::upcctl_pwr_e pwr;

    function automatic logic field(input logic [31:0] w, input int pos);
        return w[pos];
    endfunction : field

    wire logic apb_wr = PSEL && PENABLE && PWRITE && PREADY;
    wire logic int_mode = field(cfr1, `UPCCTL_F_INT_UPD);
    wire logic frame_start = gate_s2 && bit_cnt == 5'd0 && !sync_armed;
    wire logic [SAMPLE_W-1:0] next_shift = field(cfr1, `UPCCTL_F_DSP_LSB) ?
        {SAMPLE_IN[0], shift_word[SAMPLE_W-1:1]} :
        {shift_word[SAMPLE_W-2:0], SAMPLE_IN[0]};

    // Pin synchronisers
    always_ff @(posedge CLOCK) begin
        upd_s1 <= UPDATE_IN;
        upd_s2 <= upd_s1;
        upd_s3 <= upd_s2;
        gate_s1 <= TRANSMIT_GATE;
        gate_s2 <= gate_s1;
        pd_s1 <= POWER_DOWN_PIN;
        pd_s2 <= pd_s1;
        lock_s1 <= PLL_LOCK_RAW;
        lock_s2 <= lock_s1;
        serr_s1 <= SYNC_ERR_RAW;
        serr_s2 <= serr_s1;
    end

    // APB: zero wait states, error on unmapped address
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            PREADY <= PSEL && !PENABLE;
            PSLVERR <= 1'b0;
            if (PSEL && !PENABLE) begin
                unique case (PADDR)
                    `UPCCTL_ADDR_CFR1: PRDATA <= hold_cfr1;
                    `UPCCTL_ADDR_CLOCK: PRDATA <= hold_clock;
                    `UPCCTL_ADDR_RATE: PRDATA <= hold_rate;
                    `UPCCTL_ADDR_TUNE_FREQ: PRDATA <= hold_freq;
                    `UPCCTL_ADDR_TUNE_PHASE: PRDATA <= hold_phase;
                    `UPCCTL_ADDR_TUNE_AMP: PRDATA <= hold_amp;
                    `UPCCTL_ADDR_CFR2, `UPCCTL_ADDR_UPDATE: PRDATA <= 32'h0000_0000;
                    `UPCCTL_ADDR_ACTIVE1: PRDATA <= cfr1;
                    `UPCCTL_ADDR_ACTIVE2: PRDATA <= clock_cfg;
                    `UPCCTL_ADDR_ACTIVE3: PRDATA <= rate;
                    `UPCCTL_ADDR_STATUS: PRDATA <= {28'h000_0000, CORE_CLK_RUN,
                        pwr == upcctl_pkg::PWR_SLEEP, lock_s2, SYNC_ERR_FLAG};
                    default: begin
                        PRDATA <= 32'h0000_0000;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Holding registers
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            hold_cfr1 <= `UPCCTL_RST_CFR1;
            hold_clock <= `UPCCTL_RST_CLOCK;
            hold_rate <= `UPCCTL_RST_RATE;
            hold_freq <= 32'h0000_0000;
            hold_phase <= 32'h0000_0000;
            hold_amp <= 32'h0000_0000;
        end else if (apb_wr) begin
            unique case (PADDR)
                `UPCCTL_ADDR_CFR1: hold_cfr1 <= PWDATA;
                `UPCCTL_ADDR_CLOCK: hold_clock <= PWDATA;
                `UPCCTL_ADDR_RATE: hold_rate <= PWDATA;
                `UPCCTL_ADDR_TUNE_FREQ: hold_freq <= PWDATA;
                `UPCCTL_ADDR_TUNE_PHASE: hold_phase <= PWDATA;
                `UPCCTL_ADDR_TUNE_AMP: hold_amp <= PWDATA;
                default: ;
            endcase
        end
    end

    assign sw_update = apb_wr && PADDR == `UPCCTL_ADDR_UPDATE && PWDATA[`UPCCTL_F_UPD_GO];
    // Pin edge as update source only while the pin is an input
    assign transfer = sw_update || int_tick || (!int_mode && upd_s2 && !upd_s3);

    // Internal update timer
    always_ff @(posedge CLOCK) begin
        if (RESET || !int_mode) begin
            rate_cnt <= '0;
        end else if (rate_cnt >= rate[RATE_W-1:0]) begin
            rate_cnt <= '0;
        end else begin
            rate_cnt <= rate_cnt + 1'b1;
        end
    end
    assign int_tick = int_mode && rate_cnt >= rate[RATE_W-1:0];

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            UPDATE_OUT <= 1'b0;
            UPDATE_OE <= 1'b0;
        end else begin
            UPDATE_OE <= int_mode;
            UPDATE_OUT <= int_tick;
        end
    end

    // Active registers copied together
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            cfr1 <= `UPCCTL_RST_CFR1;
            clock_cfg <= `UPCCTL_RST_CLOCK;
            rate <= `UPCCTL_RST_RATE;
            act_freq <= 32'h0000_0000;
            act_phase <= 32'h0000_0000;
            act_amp <= 32'h0000_0000;
        end else if (transfer) begin
            cfr1 <= hold_cfr1;
            clock_cfg <= hold_clock;
            rate <= hold_rate;
            act_freq <= hold_freq;
            act_phase <= hold_phase;
            act_amp <= hold_amp;
        end
    end

    // Clock path and static controls
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            REF_DIV_BYPASS <= 1'b0;
            MULT_ENABLE <= 1'b0;
            MULT_FACTOR <= `UPCCTL_MULT_MIN;
            CRYSTAL_REFERENCE_OUTPUT <= upcctl_pkg::DRIVE_LOW;
            MODE <= upcctl_pkg::MODE_QUADRATURE_UPCONVERT;
            SYNC_CLK_OE <= 1'b0;
            BLOCK_PD <= 4'h0;
        end else begin
            REF_DIV_BYPASS <= field(clock_cfg, `UPCCTL_F_DIV_OFF);
            MULT_ENABLE <= field(clock_cfg, `UPCCTL_F_MULT_EN);
            // Out-of-range factors clamp into 12..127
            MULT_FACTOR <= clock_cfg[`UPCCTL_F_MULT_LO +: 7] < `UPCCTL_MULT_MIN ?
                `UPCCTL_MULT_MIN : clock_cfg[`UPCCTL_F_MULT_LO +: 7];
            CRYSTAL_REFERENCE_OUTPUT <= clock_cfg[`UPCCTL_F_XTAL_LO +: 2] ==
                upcctl_pkg::DRIVE_SPARE ? upcctl_pkg::DRIVE_HIGH :
                clock_cfg[`UPCCTL_F_XTAL_LO +: 2];
            MODE <= cfr1[`UPCCTL_F_MODE_LO +: 2] == upcctl_pkg::MODE_SPARE ?
                upcctl_pkg::MODE_QUADRATURE_UPCONVERT : cfr1[`UPCCTL_F_MODE_LO +: 2];
            SYNC_CLK_OE <= field(cfr1, `UPCCTL_F_SYNC_CLK_EN);
            BLOCK_PD <= {field(cfr1, `UPCCTL_F_PD_AUX), field(cfr1, `UPCCTL_F_PD_CLK),
                field(cfr1, `UPCCTL_F_PD_DAC), field(cfr1, `UPCCTL_F_PD_DIG)};
        end
    end

    assign gate_on = gate_s2 ^ field(cfr1, `UPCCTL_F_GATE_INV);

    // Power control: auto sleep and pin power-down
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            pwr <= upcctl_pkg::PWR_RUN;
            flush_cnt <= 8'h00;
        end else begin
            unique case (pwr)
                upcctl_pkg::PWR_RUN: begin
                    flush_cnt <= 8'h00;
                    if (field(cfr1, `UPCCTL_F_AUTO_SLEEP) && !gate_on) begin
                        pwr <= upcctl_pkg::PWR_FLUSH;
                    end
                end
                upcctl_pkg::PWR_FLUSH: begin
                    flush_cnt <= flush_cnt + 8'h01;
                    if (gate_on || !field(cfr1, `UPCCTL_F_AUTO_SLEEP)) begin
                        pwr <= upcctl_pkg::PWR_RUN;
                    end else if (flush_cnt == `UPCCTL_FLUSH_CYCLES - 8'h01) begin
                        pwr <= upcctl_pkg::PWR_SLEEP;
                    end
                end
                upcctl_pkg::PWR_SLEEP: begin
                    if (gate_on || !field(cfr1, `UPCCTL_F_AUTO_SLEEP)) begin
                        pwr <= upcctl_pkg::PWR_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            CORE_CLK_RUN <= 1'b1;
            BIAS_ON <= 1'b1;
        end else begin
            CORE_CLK_RUN <= pwr != upcctl_pkg::PWR_SLEEP &&
                !(pd_s2 && field(cfr1, `UPCCTL_F_EXT_PD_FULL));
            BIAS_ON <= !(pd_s2 && field(cfr1, `UPCCTL_F_EXT_PD_FULL));
        end
    end

    // Data assembler: format, gating, flush and mute
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            last_sample <= '0;
            SAMPLE_OUT <= '0;
        end else begin
            if (SAMPLE_VALID && gate_on) begin
                // Offset binary becomes two's complement by flipping the sign
                last_sample <= field(cfr1, `UPCCTL_F_FMT) ?
                    SAMPLE_IN ^ {1'b1, {(SAMPLE_W-1){1'b0}}} : SAMPLE_IN;
            end
            if (pd_s2 || pwr != upcctl_pkg::PWR_RUN) begin
                SAMPLE_OUT <= '0;
            end else if (gate_on || field(cfr1, `UPCCTL_F_HOLD_LAST)) begin
                SAMPLE_OUT <= last_sample;
            end else begin
                SAMPLE_OUT <= '0;
            end
        end
    end

    // Parallel data clock
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ser_phase <= 1'b0;
            PARALLEL_DATA_CLOCK <= 1'b0;
        end else begin
            if (SAMPLE_VALID) begin
                ser_phase <= ~ser_phase;
            end
            PARALLEL_DATA_CLOCK <= field(cfr1, `UPCCTL_F_PARALLEL_DATA_CLOCK_EN) &&
                ((field(cfr1, `UPCCTL_F_PARALLEL_DATA_CLOCK_HALF) ? ser_phase : SAMPLE_VALID)
                ^ field(cfr1, `UPCCTL_F_PARALLEL_DATA_CLOCK_INV));
        end
    end

    // DSP serial port compatible input: frame sync on transmit gate, data on SAMPLE_IN[0]
    always_ff @(posedge CLOCK) begin
        if (RESET || !field(cfr1, `UPCCTL_F_DSP_EN)) begin
            shift_word <= '0;
            bit_cnt <= 5'd0;
            sync_armed <= 1'b0;
            SERIAL_WORD <= '0;
        end else if (SAMPLE_VALID) begin
            // Early sync: data starts the strobe after the sync; late: with it
            if (frame_start && field(cfr1, `UPCCTL_F_DSP_EARLY)) begin
                sync_armed <= 1'b1;
            end else if (frame_start || sync_armed || bit_cnt != 5'd0) begin
                sync_armed <= 1'b0;
                shift_word <= next_shift;
                bit_cnt <= bit_cnt == 5'(SAMPLE_W - 1) ? 5'd0 : bit_cnt + 5'd1;
                if (bit_cnt == 5'(SAMPLE_W - 1)) begin
                    SERIAL_WORD <= next_shift;
                end
            end
        end
    end

    // Sync error flag, set wins over clear by status write
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            SYNC_ERR_FLAG <= 1'b0;
        end else if (field(cfr1, `UPCCTL_F_SYNC_ERR_EN) && serr_s2) begin
            SYNC_ERR_FLAG <= 1'b1;
        end else if (apb_wr && PADDR == `UPCCTL_ADDR_STATUS && PWDATA[`UPCCTL_F_SYNC_ERR]) begin
            SYNC_ERR_FLAG <= 1'b0;
        end
    end

    // Tuning words: matched or staggered latency
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            freq_d1 <= 32'h0000_0000;
            freq_d2 <= 32'h0000_0000;
            amp_d1 <= 32'h0000_0000;
            TUNE_FREQ <= 32'h0000_0000;
            TUNE_PHASE <= 32'h0000_0000;
            TUNE_AMP <= 32'h0000_0000;
        end else begin
            freq_d1 <= act_freq;
            freq_d2 <= freq_d1;
            amp_d1 <= act_amp;
            if (field(cfr1, `UPCCTL_F_MATCHED)) begin
                TUNE_FREQ <= act_freq;
                TUNE_AMP <= act_amp;
            end else begin
                TUNE_FREQ <= freq_d2;
                TUNE_AMP <= amp_d1;
            end
            TUNE_PHASE <= act_phase;
        end
    end

    chk_update_copies: assert property (@(posedge CLOCK) disable iff (RESET)
        transfer |=> cfr1 == $past(hold_cfr1) && act_freq == $past(hold_freq))
        else $error("update did not copy holding registers");
    chk_hold_isolated: assert property (@(posedge CLOCK) disable iff (RESET)
        !transfer |=> $stable(cfr1) && $stable(act_amp))
        else $error("active register changed without update");
    chk_int_pulse: assert property (@(posedge CLOCK) disable iff (RESET)
        int_tick |=> UPDATE_OUT && UPDATE_OE)
        else $error("internal update pulse missing");
    chk_mult_range: assert property (@(posedge CLOCK) disable iff (RESET)
        MULT_FACTOR >= `UPCCTL_MULT_MIN)
        else $error("multiplier below minimum");
    chk_flush_sleep: assert property (@(posedge CLOCK) disable iff (RESET)
        pwr == upcctl_pkg::PWR_SLEEP |=> !CORE_CLK_RUN || $past(gate_on)
            || !$past(field(cfr1, `UPCCTL_F_AUTO_SLEEP)))
        else $error("clocks run during auto sleep");
    chk_wake_gate: assert property (@(posedge CLOCK) disable iff (RESET)
        pwr == upcctl_pkg::PWR_SLEEP && gate_on |=> pwr == upcctl_pkg::PWR_RUN)
        else $error("no wake on gate");
    chk_zero_gate: assert property (@(posedge CLOCK) disable iff (RESET)
        !gate_on && !field(cfr1, `UPCCTL_F_HOLD_LAST) |=> SAMPLE_OUT == '0)
        else $error("assembler not zero with gate off");
    chk_fast_mute: assert property (@(posedge CLOCK) disable iff (RESET)
        pd_s2 && !field(cfr1, `UPCCTL_F_EXT_PD_FULL) && pwr == upcctl_pkg::PWR_RUN
            |=> SAMPLE_OUT == '0 && CORE_CLK_RUN && BIAS_ON)
        else $error("fast recovery power-down wrong");
    chk_full_pd: assert property (@(posedge CLOCK) disable iff (RESET)
        pd_s2 && field(cfr1, `UPCCTL_F_EXT_PD_FULL) |=> !CORE_CLK_RUN && !BIAS_ON)
        else $error("full power-down wrong");
    chk_sync_flag: assert property (@(posedge CLOCK) disable iff (RESET)
        field(cfr1, `UPCCTL_F_SYNC_ERR_EN) && serr_s2 |=> SYNC_ERR_FLAG)
        else $error("sync error not flagged");
    chk_matched_words: assert property (@(posedge CLOCK) disable iff (RESET)
        field(cfr1, `UPCCTL_F_MATCHED) |=> TUNE_FREQ == $past(act_freq)
            && TUNE_AMP == $past(act_amp))
        else $error("matched latency broken");
endmodule : upcctl_top
`default_nettype wire

// [verification/test_upcctl_top.sv]
// Directed bench for the upconverter chip control over APB.
// Assumes upcctl_top and the host model upcctl_host.
`include "upcctl_map.svh"
`timescale 1ns/1ns
`default_nettype none
module test_upcctl_top;
    logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, tf, tp, ta;
    logic pready, pslverr, pd_pin = 0, lock_raw = 0, err_raw = 0, gate, valid;
    logic [15:0] sample, sample_out, serial_word;
    logic [6:0] factor;
    logic [1:0] xtal, mode;
    logic [3:0] block_pd;
    logic upd_out, upd_oe, pdc, sync_oe, div_byp, mult_en, clk_run, bias_on, sync_flag;
    int failures = 0, tests_run = 0, pulses = 0;
    logic upd_pin = 0, p;
    always #20 clock = ~clock;
    upcctl_top i_dut (.CLOCK(clock), .RESET(reset), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .UPDATE_IN(upd_pin), .UPDATE_OUT(upd_out), .UPDATE_OE(upd_oe),
        .TRANSMIT_GATE(gate), .POWER_DOWN_PIN(pd_pin), .PLL_LOCK_RAW(lock_raw),
        .SYNC_ERR_RAW(err_raw), .SAMPLE_IN(sample), .SAMPLE_VALID(valid),
        .SAMPLE_OUT(sample_out), .SERIAL_WORD(serial_word), .TUNE_FREQ(tf), .TUNE_PHASE(tp),
        .TUNE_AMP(ta), .PARALLEL_DATA_CLOCK(pdc), .SYNC_CLK_OE(sync_oe),
        .REF_DIV_BYPASS(div_byp), .MULT_ENABLE(mult_en), .MULT_FACTOR(factor),
        .CRYSTAL_REFERENCE_OUTPUT(xtal), .MODE(mode), .CORE_CLK_RUN(clk_run),
        .BIAS_ON(bias_on), .BLOCK_PD(block_pd), .SYNC_ERR_FLAG(sync_flag));
    upcctl_host i_host (.clock(clock), .gate(gate), .sample(sample), .valid(valid));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic cfg(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        apb(1'b1, `UPCCTL_ADDR_UPDATE, 32'h0000_0001);
        repeat (2) @(posedge clock);
    endtask : cfg
    initial begin
        repeat (6) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        apb(1'b0, `UPCCTL_ADDR_ACTIVE3, 32'h0000_0000);
        check("rate", rd, `UPCCTL_RST_RATE);
        check("factor", factor, 32'd12);
        check("mult", mult_en, 32'd0);
        apb(1'b1, `UPCCTL_ADDR_CFR1, 32'h0000_0001);
        apb(1'b0, `UPCCTL_ADDR_ACTIVE1, 32'h0000_0000);
        check("held", rd, 32'h0000_0000);
        check("mode", mode, 32'd0);
        for (int m = 0; m < 4; m++) begin
            cfg(`UPCCTL_ADDR_CFR1, 32'(m));
            check("mode", mode, 32'(m % 3));
        end
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        check("slverr", err, 32'd1);
        $display("test update and mode done");
        cfg(`UPCCTL_ADDR_CLOCK, 32'h0000_05FF);
        check("factor", factor, 32'd127);
        check("bypass", div_byp, 32'd1);
        for (int x = 0; x < 4; x++) begin
            cfg(`UPCCTL_ADDR_CLOCK, 32'(x * 512 + 50));
            check("drive", xtal, 32'(x - x / 3));
            check("bypass", div_byp, 32'd0);
        end
        for (int i = 0; i < 4; i++) begin
            cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0800 << i);
            check("block pd", block_pd, 32'd1 << i);
        end
        cfg(`UPCCTL_ADDR_CFR1, 32'h0004_0000);
        check("sync oe", sync_oe, 32'd1);
        $display("test clock and power bits done");
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_8000);
        i_host.set_gate(1'b0);
        repeat (12) @(posedge clock);
        check("flushing", clk_run, 32'd1);
        repeat (12) @(posedge clock);
        check("asleep", clk_run, 32'd0);
        i_host.set_gate(1'b1);
        repeat (5) @(posedge clock);
        check("awake", clk_run, 32'd1);
        pd_pin <= 1'b1;
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0000);
        check("fast pd", {clk_run, bias_on}, 32'd3);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0001_0000);
        check("full pd", {clk_run, bias_on}, 32'd0);
        pd_pin <= 1'b0;
        lock_raw <= 1'b1;
        cfg(`UPCCTL_ADDR_CFR1, 32'h0002_0000);
        err_raw <= 1'b1;
        repeat (4) @(posedge clock);
        err_raw <= 1'b0;
        apb(1'b0, `UPCCTL_ADDR_STATUS, 32'h0000_0000);
        check("lock", rd[1], 32'd1);
        check("sync flag", sync_flag, 32'd1);
        $display("test sleep and status done");
        for (int k = 0; k < 4; k++) begin
            cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0100 | 32'(k * 512));
            i_host.send_word(16'hA5C3, k[0], k[1]);
            repeat (6) @(posedge clock);
            check("serial", serial_word, 32'h0000_A5C3);
        end
        $display("test serial done");
        cfg(`UPCCTL_ADDR_RATE, 32'h0000_0003);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0010_0000);
        for (int c = 0; c < 16; c++) begin
            @(posedge clock);
            pulses += int'(upd_out === 1'b1);
        end
        check("update pulses", pulses, 32'd4);
        check("update oe", upd_oe, 32'd1);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0000);
        check("update oe off", upd_oe, 32'd0);
        apb(1'b1, `UPCCTL_ADDR_CFR1, 32'h0000_0002);
        upd_pin <= 1'b1;
        repeat (5) @(posedge clock);
        upd_pin <= 1'b0;
        check("pin update", mode, 32'd2);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0008_0000);
        apb(1'b1, `UPCCTL_ADDR_TUNE_FREQ, 32'h1111_1111);
        apb(1'b1, `UPCCTL_ADDR_TUNE_PHASE, 32'h2222_2222);
        apb(1'b1, `UPCCTL_ADDR_TUNE_AMP, 32'h3333_3333);
        apb(1'b1, `UPCCTL_ADDR_UPDATE, 32'h0000_0001);
        @(negedge clock);
        check("matched", {tf[3:0], tp[3:0], ta[3:0]}, 32'h0000_0123);
        @(posedge clock);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0000);
        apb(1'b1, `UPCCTL_ADDR_TUNE_FREQ, 32'h4444_4444);
        apb(1'b1, `UPCCTL_ADDR_TUNE_PHASE, 32'h5555_5555);
        apb(1'b1, `UPCCTL_ADDR_TUNE_AMP, 32'h6666_6666);
        apb(1'b1, `UPCCTL_ADDR_UPDATE, 32'h0000_0001);
        @(negedge clock);
        check("staggered", {tf[3:0], tp[3:0], ta[3:0]}, 32'h0000_0153);
        @(posedge clock);
        $display("test update sources and tuning done");
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0004);
        i_host.set_gate(1'b1);
        repeat (3) @(posedge clock);
        i_host.put_sample(16'h0123);
        repeat (2) @(posedge clock);
        check("offset binary", sample_out, 32'h0000_8123);
        i_host.set_gate(1'b0);
        repeat (4) @(posedge clock);
        check("gate zero", sample_out, 32'h0000_0000);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0080);
        check("hold last", sample_out, 32'h0000_8123);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0008);
        i_host.put_sample(16'h0123);
        repeat (2) @(posedge clock);
        check("gate inverted", sample_out, 32'h0000_0123);
        pd_pin <= 1'b1;
        repeat (4) @(posedge clock);
        check("fast mute", sample_out, 32'h0000_0000);
        pd_pin <= 1'b0;
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0030);
        check("parallel_data_clock inverted", pdc, 32'd1);
        cfg(`UPCCTL_ADDR_CFR1, 32'h0000_0050);
        p = pdc;
        i_host.put_sample(16'h0000);
        repeat (2) @(posedge clock);
        check("parallel_data_clock half", pdc, 32'(!p));
        $display("test data path done");
        summarize();
    end
endmodule : test_upcctl_top
`default_nettype wire

// [verification/upcctl_host.sv]
// Model of the external controller: transmit gate and baseband samples.
// Assumes the device samples SAMPLE_IN[0] on each valid strobe in serial mode.
`timescale 1ns/1ns
`default_nettype none
module upcctl_host (
    // Clock
    input wire logic clock,
    // Pins toward the device
    output logic gate,
    output logic [15:0] sample,
    output logic valid
);
    initial begin
        gate = 1'b1;
        sample = 16'h0000;
        valid = 1'b0;
    end
    task automatic set_gate(input logic v);
        @(posedge clock);
        gate <= v;
    endtask : set_gate
    // One parallel sample strobe
    task automatic put_sample(input logic [15:0] s);
        @(posedge clock);
        sample <= s;
        valid <= 1'b1;
        @(posedge clock);
        valid <= 1'b0;
    endtask : put_sample
    // Serial word; sync pin leads the data by the device's two-stage sync
    task automatic send_word(input logic [15:0] w, input logic lsb, input logic early);
        @(posedge clock);
        gate <= 1'b1;
        @(posedge clock);
        gate <= 1'b0;
        @(posedge clock);
        if (early) begin
            sample <= 16'h0000;
            valid <= 1'b1;
            @(posedge clock);
        end
        for (int i = 0; i < 16; i++) begin
            sample <= {15'h0, lsb ? w[i] : w[15 - i]};
            valid <= 1'b1;
            @(posedge clock);
        end
        // Released data line toggles instead of holding the last bit
        valid <= 1'b0;
        sample <= ~sample;
    endtask : send_word
endmodule : upcctl_host
`default_nettype wire
